// ===== store_pkg.sv
// Purpose: shared constants and types for the still store control block
// Assumes: one 50 MHz clock, fields framed by a field-start pulse
// Notes: register offsets and field positions live here only
package store_pkg;

    // ==========================================================
    // picture geometry
    localparam int PIX_W = 8;
    localparam int X_W = 4;
    localparam int Y_W = 4;
    localparam int LINE_PIX = 16;
    localparam int FIELD_LINES = 16;
    localparam int FRAME_ADDR_W = 1 + Y_W + X_W;
    localparam int FRAME_WORDS = 2 * LINE_PIX * FIELD_LINES;
    localparam logic [X_W-1:0] X_LAST = 4'hf;
    localparam logic [Y_W-1:0] Y_LAST = 4'hf;

    // ==========================================================
    // field sequencing
    localparam int FILL_FIELDS = 2;
    localparam logic FILL_LAST = 1'(FILL_FIELDS - 1);
    localparam int LINGER_W = 3;
    localparam logic [LINGER_W-1:0] GRAB_LINGER_FIELDS = 3'h4;
    localparam int CH_VIDEO = 0;
    localparam int CH_KEY = 1;

    // ==========================================================
    // register port
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 32;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FIELD = 8'h04;
    localparam logic [7:0] REG_SHADOW = 8'h08;
    localparam logic [7:0] REG_ROUTE = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;

    localparam int CTRL_DELEG_LSB = 0;
    localparam int CTRL_FREEZE_BIT = 2;
    localparam int CTRL_GRAB_BIT = 3;
    localparam int CTRL_SHADOW_BIT = 4;
    localparam int FIELD_VIDEO_LSB = 0;
    localparam int FIELD_KEY_LSB = 2;
    localparam int FIELD_INTERP_BIT = 4;
    localparam int SHADOW_HOFF_LSB = 0;
    localparam int SHADOW_VOFF_LSB = 8;
    localparam int SHADOW_OPAC_LSB = 16;
    localparam int ROUTE_SEL_LSB = 0;
    localparam int ROUTE_FMT_BIT = 2;
    localparam int STAT_FROZEN_LSB = 0;
    localparam int STAT_GRAB_LSB = 2;
    localparam int STAT_SHADOW_BIT = 4;
    localparam int STAT_LOOP_BIT = 5;
    localparam int STAT_VSTATE_LSB = 6;
    localparam int STAT_KSTATE_LSB = 8;

    // ==========================================================
    // values after reset
    localparam logic [1:0] DELEG_RST = 2'h1;
    localparam logic [1:0] FSEL_RST = 2'h3;
    localparam logic [7:0] HOFF_RST = 8'h02;
    localparam logic [7:0] VOFF_RST = 8'h02;
    localparam logic [7:0] OPAC_RST = 8'h80;

    // ==========================================================
    // types
    typedef struct packed {
        logic [PIX_W-1:0] video;
        logic [PIX_W-1:0] key;
    } pix_s;

    typedef enum logic [1:0] {
        ST_LIVE = 2'b00,
        ST_GRAB = 2'b01,
        ST_FROZEN = 2'b11,
        ST_REGRAB = 2'b10
    } frz_state_e;

    typedef enum logic [1:0] {
        ROUTE_NONE = 2'h0,
        ROUTE_EXTERNAL = 2'h1,
        ROUTE_STORE = 2'h2
    } route_e;

endpackage

// ===== still_store.sv
// Purpose: freeze/grab control, field readout, drop shadow and loop routing
//          for a video/key still store
// Assumes: field_start_i pulses once per field before its first pixel;
//          field_id_i is valid with it; register port with one-cycle read
// Notes: store outputs lag the 2-field delay by one pipeline clock
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module still_store (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [store_pkg::REG_ADDR_W-1:0] addr_i,
    input wire logic [store_pkg::REG_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [store_pkg::REG_DATA_W-1:0] rdata_o,
    input wire logic field_start_i,
    input wire logic field_id_i,
    input wire logic pix_valid_i,
    input wire store_pkg::pix_s aux_pair_i,
    input wire store_pkg::pix_s keyer_i,
    input wire store_pkg::pix_s ext_ret_i,
    input wire logic opt_store_i,
    input wire logic opt_send_i,
    output store_pkg::pix_s xpt_o,
    output store_pkg::pix_s outmod_o,
    output store_pkg::pix_s mix_return_o,
    output store_pkg::pix_s aux_send_o,
    output store_pkg::pix_s ext_col_o,
    output logic pix_valid_o,
    output logic [1:0] frozen_o,
    output logic [1:0] grab_lit_o,
    output logic shadow_on_o
);
    import store_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [1:0] pick_field(input frz_state_e st, input logic [1:0] fsel,
                                              input logic fld);
        logic f;
        f = fld;
        if (st == ST_FROZEN && (fsel == 2'b01 || fsel == 2'b10)) begin
            f = fsel[1];
        end
        return {f != fld, f};
    endfunction

    function automatic logic [PIX_W-1:0] blend(input logic [PIX_W-1:0] a,
                                               input logic [PIX_W-1:0] b, input logic interp);
        logic [PIX_W:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return interp ? sum[PIX_W:1] : a;
    endfunction

    function automatic logic [Y_W-1:0] below(input logic [Y_W-1:0] y);
        return (y == Y_LAST) ? y : y + 4'h1;
    endfunction

    // ==========================================================
    // register port
    logic [1:0] deleg_reg, deleg_next;
    logic grab_hold_reg, grab_hold_next;
    logic shadow_reg, shadow_next;
    logic [1:0] fsel_reg [2];
    logic [1:0] fsel_next [2];
    logic interp_reg, interp_next;
    logic [7:0] hoff_reg, hoff_next, voff_reg, voff_next, opac_reg, opac_next;
    route_e route_reg, route_next;
    logic fmt_reg, fmt_next;
    logic [REG_DATA_W-1:0] rdata_reg, rdata_next;
    logic freeze_cmd, grab_cmd;
    logic loop_on;
    frz_state_e state_reg [2];
    logic [1:0] frozen_reg, grab_lit_reg;

    assign loop_on = (route_reg == ROUTE_STORE) && opt_store_i && opt_send_i;

    always_comb begin
        deleg_next = deleg_reg;
        grab_hold_next = grab_hold_reg;
        shadow_next = shadow_reg;
        fsel_next = fsel_reg;
        interp_next = interp_reg;
        hoff_next = hoff_reg;
        voff_next = voff_reg;
        opac_next = opac_reg;
        route_next = route_reg;
        fmt_next = fmt_reg;
        freeze_cmd = 1'b0;
        grab_cmd = 1'b0;
        rdata_next = '0;
        if (wr_i) begin
            unique case (addr_i)
                REG_CTRL: begin
                    deleg_next = wdata_i[CTRL_DELEG_LSB +: 2];
                    if (deleg_next == 2'b00) begin
                        deleg_next = DELEG_RST;
                    end
                    freeze_cmd = wdata_i[CTRL_FREEZE_BIT];
                    grab_hold_next = wdata_i[CTRL_GRAB_BIT];
                    grab_cmd = wdata_i[CTRL_GRAB_BIT] & ~grab_hold_reg;
                    shadow_next = shadow_reg ^ wdata_i[CTRL_SHADOW_BIT];
                end
                REG_FIELD: begin
                    if (deleg_reg[CH_VIDEO]) begin
                        fsel_next[CH_VIDEO] = wdata_i[FIELD_VIDEO_LSB +: 2];
                    end
                    if (deleg_reg[CH_KEY]) begin
                        fsel_next[CH_KEY] = wdata_i[FIELD_KEY_LSB +: 2];
                    end
                    if (deleg_reg == 2'b11) begin
                        fsel_next[CH_KEY] = wdata_i[FIELD_VIDEO_LSB +: 2];
                    end
                    interp_next = wdata_i[FIELD_INTERP_BIT];
                end
                REG_SHADOW: begin
                    hoff_next = wdata_i[SHADOW_HOFF_LSB +: 8];
                    voff_next = wdata_i[SHADOW_VOFF_LSB +: 8];
                    opac_next = wdata_i[SHADOW_OPAC_LSB +: 8];
                end
                REG_ROUTE: begin
                    route_next = route_e'(wdata_i[ROUTE_SEL_LSB +: 2]);
                    fmt_next = wdata_i[ROUTE_FMT_BIT];
                end
                default: ;
            endcase
        end
        if (rd_i) begin
            unique case (addr_i)
                REG_CTRL: begin
                    rdata_next[CTRL_DELEG_LSB +: 2] = deleg_reg;
                    rdata_next[CTRL_GRAB_BIT] = grab_hold_reg;
                    rdata_next[CTRL_SHADOW_BIT] = shadow_reg;
                end
                REG_FIELD: begin
                    rdata_next[FIELD_VIDEO_LSB +: 2] = fsel_reg[CH_VIDEO];
                    rdata_next[FIELD_KEY_LSB +: 2] = fsel_reg[CH_KEY];
                    rdata_next[FIELD_INTERP_BIT] = interp_reg;
                end
                REG_SHADOW: begin
                    rdata_next[SHADOW_HOFF_LSB +: 8] = hoff_reg;
                    rdata_next[SHADOW_VOFF_LSB +: 8] = voff_reg;
                    rdata_next[SHADOW_OPAC_LSB +: 8] = opac_reg;
                end
                REG_ROUTE: begin
                    rdata_next[ROUTE_SEL_LSB +: 2] = route_reg;
                    rdata_next[ROUTE_FMT_BIT] = fmt_reg;
                end
                REG_STATUS: begin
                    rdata_next[STAT_FROZEN_LSB +: 2] = frozen_reg;
                    rdata_next[STAT_GRAB_LSB +: 2] = grab_lit_reg;
                    rdata_next[STAT_SHADOW_BIT] = shadow_on_o;
                    rdata_next[STAT_LOOP_BIT] = loop_on;
                    rdata_next[STAT_VSTATE_LSB +: 2] = state_reg[CH_VIDEO];
                    rdata_next[STAT_KSTATE_LSB +: 2] = state_reg[CH_KEY];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            deleg_reg <= DELEG_RST;
            grab_hold_reg <= 1'b0;
            shadow_reg <= 1'b0;
            fsel_reg <= '{FSEL_RST, FSEL_RST};
            interp_reg <= 1'b0;
            hoff_reg <= HOFF_RST;
            voff_reg <= VOFF_RST;
            opac_reg <= OPAC_RST;
            route_reg <= ROUTE_NONE;
            fmt_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            deleg_reg <= deleg_next;
            grab_hold_reg <= grab_hold_next;
            shadow_reg <= shadow_next;
            fsel_reg <= fsel_next;
            interp_reg <= interp_next;
            hoff_reg <= hoff_next;
            voff_reg <= voff_next;
            opac_reg <= opac_next;
            route_reg <= route_next;
            fmt_reg <= fmt_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;

    // ==========================================================
    // per-channel freeze sequencing, applied at field starts
    frz_state_e state_next [2];
    logic cnt_reg [2];
    logic cnt_next [2];
    logic [1:0] pend_frz_reg, pend_frz_next, pend_grab_reg, pend_grab_next;
    logic [LINGER_W-1:0] linger_reg [2];
    logic [LINGER_W-1:0] linger_next [2];
    logic [1:0] fsel_eff_reg [2];
    logic [1:0] fsel_eff_next [2];
    logic interp_eff_reg, shadow_eff_reg;
    logic [7:0] hoff_eff_reg, voff_eff_reg, opac_eff_reg;
    logic [1:0] frozen_next, grab_lit_next;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            pend_frz_next[c] = (pend_frz_reg[c] & ~field_start_i) | (freeze_cmd & deleg_reg[c]);
            pend_grab_next[c] = (pend_grab_reg[c] & ~field_start_i) | (grab_cmd & deleg_reg[c]);
            state_next[c] = state_reg[c];
            cnt_next[c] = cnt_reg[c];
            fsel_eff_next[c] = field_start_i ? fsel_reg[c] : fsel_eff_reg[c];
            if (field_start_i) begin
                unique case (state_reg[c])
                    ST_LIVE: begin
                        if (pend_grab_reg[c]) begin
                            state_next[c] = ST_GRAB;
                            cnt_next[c] = 1'b0;
                        end else if (pend_frz_reg[c]) begin
                            state_next[c] = ST_FROZEN;
                        end
                    end
                    ST_FROZEN: begin
                        if (pend_frz_reg[c]) begin
                            state_next[c] = ST_LIVE;
                        end else if (pend_grab_reg[c]) begin
                            state_next[c] = ST_REGRAB;
                            cnt_next[c] = 1'b0;
                        end
                    end
                    ST_GRAB, ST_REGRAB: begin
                        if (pend_frz_reg[c]) begin
                            state_next[c] = ST_LIVE;
                        end else if (cnt_reg[c] == FILL_LAST) begin
                            state_next[c] = ST_FROZEN;
                        end else begin
                            cnt_next[c] = 1'b1;
                        end
                    end
                endcase
            end
            // lamp lit while held, then a few fields of afterglow
            if (grab_hold_reg && deleg_reg[c]) begin
                linger_next[c] = GRAB_LINGER_FIELDS;
            end else if (field_start_i && linger_reg[c] != '0) begin
                linger_next[c] = linger_reg[c] - 3'h1;
            end else begin
                linger_next[c] = linger_reg[c];
            end
        end
        if (deleg_reg == 2'b11) begin
            state_next[CH_KEY] = state_next[CH_VIDEO];
            cnt_next[CH_KEY] = cnt_next[CH_VIDEO];
            linger_next[CH_KEY] = linger_next[CH_VIDEO];
            fsel_eff_next[CH_KEY] = fsel_eff_next[CH_VIDEO];
        end
        for (int c = 0; c < 2; c++) begin
            frozen_next[c] = state_next[c] != ST_LIVE;
            grab_lit_next[c] = linger_next[c] != '0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= '{ST_LIVE, ST_LIVE};
            cnt_reg <= '{1'b0, 1'b0};
            pend_frz_reg <= '0;
            pend_grab_reg <= '0;
            linger_reg <= '{'0, '0};
            fsel_eff_reg <= '{FSEL_RST, FSEL_RST};
            interp_eff_reg <= 1'b0;
            shadow_eff_reg <= 1'b0;
            hoff_eff_reg <= HOFF_RST;
            voff_eff_reg <= VOFF_RST;
            opac_eff_reg <= OPAC_RST;
            frozen_reg <= '0;
            grab_lit_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pend_frz_reg <= pend_frz_next;
            pend_grab_reg <= pend_grab_next;
            linger_reg <= linger_next;
            fsel_eff_reg <= fsel_eff_next;
            frozen_reg <= frozen_next;
            grab_lit_reg <= grab_lit_next;
            if (field_start_i) begin
                interp_eff_reg <= interp_reg;
                shadow_eff_reg <= shadow_reg;
                hoff_eff_reg <= hoff_reg;
                voff_eff_reg <= voff_reg;
                opac_eff_reg <= opac_reg;
            end
        end
    end

    assign frozen_o = frozen_reg;
    assign grab_lit_o = grab_lit_reg;
    assign shadow_on_o = shadow_eff_reg;

    // ==========================================================
    // raster position inside the current field
    logic [X_W-1:0] x_reg, x_next;
    logic [Y_W-1:0] y_reg, y_next;
    logic fld_reg, fld_next;

    always_comb begin
        x_next = x_reg;
        y_next = y_reg;
        fld_next = fld_reg;
        if (field_start_i) begin
            x_next = '0;
            y_next = '0;
            fld_next = field_id_i;
        end else if (pix_valid_i) begin
            x_next = x_reg + 4'h1;
            if (x_reg == X_LAST) begin
                y_next = below(y_reg);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            x_reg <= '0;
            y_reg <= '0;
            fld_reg <= 1'b0;
        end else begin
            x_reg <= x_next;
            y_reg <= y_next;
            fld_reg <= fld_next;
        end
    end

    // ==========================================================
    // frame memories: old word read in the same cycle it is replaced
    logic [PIX_W-1:0] vmem [FRAME_WORDS];
    logic [PIX_W-1:0] kmem [FRAME_WORDS];
    logic [FRAME_ADDR_W-1:0] wr_addr;
    logic [1:0] wen;
    pix_s store_in;

    assign wr_addr = {fld_reg, y_reg, x_reg};
    assign store_in = loop_on ? keyer_i : aux_pair_i;
    assign wen[CH_VIDEO] = pix_valid_i && state_reg[CH_VIDEO] != ST_FROZEN;
    assign wen[CH_KEY] = pix_valid_i && state_reg[CH_KEY] != ST_FROZEN;

    always_ff @(posedge clk_i) begin
        if (wen[CH_VIDEO]) begin
            vmem[wr_addr] <= store_in.video;
        end
        if (wen[CH_KEY]) begin
            kmem[wr_addr] <= store_in.key;
        end
    end

    // ==========================================================
    // readout, shadow and routing
    logic [1:0] vpick, kpick;
    logic [PIX_W-1:0] vout, kraw, kshadow, kout;
    logic [15:0] shade;
    logic shadow_hit;
    pix_s store_out;
    pix_s xpt_reg, xpt_next, mix_reg, mix_next, aux_reg, aux_next, ext_reg, ext_next;
    logic valid_reg;

    always_comb begin
        // live: same field parity one frame back, i.e. two fields ago
        vpick = pick_field(state_reg[CH_VIDEO], fsel_eff_reg[CH_VIDEO], fld_reg);
        kpick = pick_field(state_reg[CH_KEY], fsel_eff_reg[CH_KEY], fld_reg);
        vout = blend(vmem[{vpick[0], y_reg, x_reg}], vmem[{vpick[0], below(y_reg), x_reg}],
                     vpick[1] & interp_eff_reg);
        kraw = blend(kmem[{kpick[0], y_reg, x_reg}], kmem[{kpick[0], below(y_reg), x_reg}],
                     kpick[1] & interp_eff_reg);
        // unfiltered key tap, so shadow costs no key bandwidth
        shadow_hit = ({4'h0, x_reg} >= hoff_eff_reg) && ({4'h0, y_reg} >= voff_eff_reg);
        shade = {8'h00, kmem[{kpick[0], y_reg - voff_eff_reg[Y_W-1:0],
                              x_reg - hoff_eff_reg[X_W-1:0]}]} * {8'h00, opac_eff_reg};
        kshadow = shadow_hit ? shade[15:8] : '0;
        kout = (shadow_eff_reg && kshadow > kraw) ? kshadow : kraw;
        store_out.video = vout;
        store_out.key = kout;
        xpt_next = store_out;
        aux_next = keyer_i;
        if (loop_on) begin
            mix_next = store_out;
            ext_next = '0;
        end else if (route_reg == ROUTE_EXTERNAL && opt_send_i) begin
            mix_next = ext_ret_i;
            ext_next = '0;
        end else begin
            mix_next = keyer_i;
            ext_next = ext_ret_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xpt_reg <= '0;
            mix_reg <= '0;
            aux_reg <= '0;
            ext_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            xpt_reg <= xpt_next;
            mix_reg <= mix_next;
            aux_reg <= aux_next;
            ext_reg <= ext_next;
            valid_reg <= pix_valid_i;
        end
    end

    assign xpt_o = xpt_reg;
    assign outmod_o = xpt_reg;
    assign mix_return_o = mix_reg;
    assign aux_send_o = aux_reg;
    assign ext_col_o = ext_reg;
    assign pix_valid_o = valid_reg;

endmodule

// ===== store_assertions.sv
// Purpose: port checks for the still store
// Assumes: bound to still_store, one clock
// Notes: only output relations, no pixel values
`timescale 1ns/100ps
module store_assertions (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic pix_valid_i,
    input wire logic pix_valid_o,
    input wire logic field_start_i,
    input wire logic [1:0] frozen_o,
    input wire logic [1:0] grab_lit_o,
    input wire logic shadow_on_o,
    input wire logic opt_send_i,
    input wire store_pkg::pix_s keyer_i,
    input wire store_pkg::pix_s ext_ret_i,
    input wire store_pkg::pix_s xpt_o,
    input wire store_pkg::pix_s outmod_o,
    input wire store_pkg::pix_s aux_send_o,
    input wire store_pkg::pix_s ext_col_o,
    input wire store_pkg::pix_s mix_return_o
);
    import store_pkg::*;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_valid_lag: assert property (pix_valid_o == $past(pix_valid_i))
        else $error("pixel valid lag wrong");
    a_outputs_twin: assert property (outmod_o == xpt_o)
        else $error("output copies differ");
    a_freeze_edge: assert property ($changed(frozen_o) |-> $past(field_start_i))
        else $error("freeze state moved inside a field");
    a_shadow_edge: assert property ($changed(shadow_on_o) |-> $past(field_start_i))
        else $error("shadow mode moved inside a field");
    a_lamp_edge: assert property ($fell(grab_lit_o[0]) |-> $past(field_start_i))
        else $error("grab lamp dropped inside a field");
    a_send_keyer: assert property (aux_send_o == $past(keyer_i))
        else $error("send bus not keyer");
    a_column_plain: assert property (!opt_send_i |=> ext_col_o == $past(ext_ret_i))
        else $error("return column lost without send option");
    a_mix_plain: assert property (!opt_send_i |=> mix_return_o == $past(keyer_i))
        else $error("mix return rerouted without send option");
endmodule
bind still_store store_assertions chk_u (.clk_i, .rstn_i, .pix_valid_i, .pix_valid_o,
    .field_start_i, .frozen_o, .grab_lit_o, .shadow_on_o, .opt_send_i, .keyer_i,
    .ext_ret_i, .xpt_o, .outmod_o, .aux_send_o, .ext_col_o, .mix_return_o);

// ===== store_feed.sv
// Purpose: aux pair source feeding the store
// Assumes: 260 clocks a field, 256 pixels
// Notes: idle data inverts every cycle
`timescale 1ns/100ps
module store_feed (
    input wire logic clk_i,
    input wire logic rstn_i,
    output logic field_start_o,
    output logic field_id_o,
    output logic pix_valid_o,
    output store_pkg::pix_s aux_pair_o
);
    import store_pkg::*;
    logic [8:0] cnt_reg;
    logic [7:0] fcnt_reg;
    logic [7:0] idx;
    logic on;
    assign idx = 8'(cnt_reg - 9'h2);
    assign on = cnt_reg >= 9'h2 && cnt_reg < 9'h102;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 9'h0;
            fcnt_reg <= 8'h0;
            field_start_o <= 1'b0;
            field_id_o <= 1'b1;
            pix_valid_o <= 1'b0;
            aux_pair_o <= '0;
        end else begin
            cnt_reg <= (cnt_reg == 9'h103) ? 9'h0 : cnt_reg + 9'h1;
            field_start_o <= cnt_reg == 9'h0;
            if (cnt_reg == 9'h0) begin
                fcnt_reg <= fcnt_reg + 8'h1;
                field_id_o <= ~field_id_o;
            end
            pix_valid_o <= on;
            // video and key on separate members
            aux_pair_o <= on ? {8'(fcnt_reg * 37 + idx), 8'(fcnt_reg * 11 + idx * 3)} : ~aux_pair_o;
        end
    end
endmodule

// ===== tb.sv
// Purpose: self-checking bench for the still store
// Assumes: feed model makes 260-clock fields
// Notes: px works out expected pixels
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", n, e, a); end end
module tb;
    import store_pkg::*;
    logic clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic opt_store_i = 1'b0, opt_send_i = 1'b0, lp, ex;
    logic [7:0] addr_i = 8'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o, d, r32, seed = 32'h578c6fa0;
    logic field_start_i, field_id_i, pix_valid_i, pix_valid_o, shadow_on_o;
    logic [1:0] frozen_o, grab_lit_o;
    pix_s aux_pair_i, keyer_i = '0, ext_ret_i = '0, xpt_o, outmod_o, mix_return_o;
    pix_s aux_send_o, ext_col_o;
    int n_fail = 0, total_checks = 0, fn = 0, idx = 0, frz_f = 0, chk = 0, g;
    always #10 clk_i = ~clk_i;
    still_store dut_u (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .field_start_i, .field_id_i, .pix_valid_i, .aux_pair_i, .keyer_i, .ext_ret_i,
        .opt_store_i, .opt_send_i, .xpt_o, .outmod_o, .mix_return_o, .aux_send_o,
        .ext_col_o, .pix_valid_o, .frozen_o, .grab_lit_o, .shadow_on_o);
    store_feed feed_u (.clk_i, .rstn_i, .field_start_o(field_start_i),
        .field_id_o(field_id_i), .pix_valid_o(pix_valid_i), .aux_pair_o(aux_pair_i));
    function automatic logic [7:0] px(int f, int i, bit k);
        return k ? 8'(f * 11 + i * 3) : 8'(f * 37 + i);
    endfunction
    // sampled mid-cycle so registered outputs have settled
    always @(negedge clk_i) begin
        if (field_start_i) begin
            fn <= fn + 1;
            idx <= 0;
        end
        if (pix_valid_o) begin
            idx <= idx + 1;
            if (chk == 1 && fn > 2) `CHK("live video", px(fn - 2, idx, 0), xpt_o.video)
            if (chk > 0 && fn > 2 && !shadow_on_o) `CHK("key", px(fn - 2, idx, 1), xpt_o.key)
            if (chk == 2) `CHK("frozen video", px(frz_f - 2 + ((fn - frz_f) & 1), idx, 0),
                xpt_o.video)
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        v = rdata_o;
    endtask
    task automatic wf(input int n);
        repeat (n) @(posedge field_start_i);
        @(posedge clk_i);
        keyer_i <= 16'($random(seed));
        ext_ret_i <= 16'($random(seed));
        @(negedge clk_i);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        end_sim;
    end
    initial begin
        logic [7:0] ra[5] = '{REG_CTRL, REG_FIELD, REG_SHADOW, REG_ROUTE, 8'h20};
        logic [31:0] rv[5] = '{32'h1, 32'hf, 32'h800202, 32'h0, 32'h0};
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            rd(ra[k], r32);
            `CHK("reset value", rv[k], r32)
        end
        wr(REG_CTRL, 32'h0);
        rd(REG_CTRL, r32);
        `CHK("empty delegation", 32'h1, r32)
        d = $random(seed);
        wr(REG_SHADOW, d);
        rd(REG_SHADOW, r32);
        `CHK("shadow params", {8'h0, d[23:0]}, r32)
        $display("test registers done");
        chk = 1;
        wf(3);
        wr(REG_CTRL, 32'h5);
        wf(1);
        `CHK("freeze lamp", 1'b1, frozen_o[0])
        frz_f = fn;
        chk = 2;
        wf(3);
        $display("test freeze done");
        chk = 0;
        wr(REG_CTRL, 32'h9);
        wf(1);
        g = fn;
        `CHK("grab lamp", 1'b1, grab_lit_o[0])
        wr(REG_CTRL, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wf(1);
            `CHK("freeze held", 1'b1, frozen_o[0])
        end
        frz_f = g + 2;
        chk = 2;
        wf(3);
        `CHK("grab lamp off", 1'b0, grab_lit_o[0])
        chk = 0;
        wr(REG_CTRL, 32'h5);
        wf(3);
        `CHK("unfrozen", 1'b0, frozen_o[0])
        $display("test grab done");
        chk = 1;
        wr(REG_CTRL, 32'h11);
        wf(1);
        `CHK("shadow on", 1'b1, shadow_on_o)
        wf(1);
        wr(REG_CTRL, 32'h11);
        wf(1);
        `CHK("shadow off", 1'b0, shadow_on_o)
        $display("test shadow done");
        chk = 0;
        for (int k = 0; k < 12; k++) begin
            {opt_send_i, opt_store_i} <= 2'(k / 3);
            wr(REG_ROUTE, 32'(4 + k % 3));
            wf(1);
            @(negedge clk_i);
            lp = k % 3 == 2 && k / 3 == 3;
            ex = k % 3 == 1 && k / 3 >= 2;
            `CHK("mix return", lp ? xpt_o : ex ? ext_ret_i : keyer_i, mix_return_o)
            `CHK("return column", (lp || ex) ? 16'h0 : ext_ret_i, ext_col_o)
        end
        $display("test routing done");
        end_sim;
    end
endmodule
